// ==== design/counter_bank.sv ====
`timescale 1ns/10ps
module counter_bank #(
  parameter int N = 27,
  parameter int W = 32,
  parameter int AW = 5
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic [N-1:0] inc_i,
  input wire logic rd_i,
  input wire logic [AW-1:0] rd_idx_i,
  input wire logic aux_sel_i,
  input wire logic [W-1:0] aux_data_i,
  output logic [W-1:0] rdata_o
);
  logic [W-1:0] cnt_ff [N];
  logic [W-1:0] nxt_rdata;

  // ********************************
  // Counters
  // ********************************
  // Clear beats a same-cycle increment so a cleared port reads zero
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < N; i++) begin
        cnt_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (clr_i) begin
          cnt_ff[i] <= '0;
        end else if (inc_i[i]) begin
          cnt_ff[i] <= cnt_ff[i] + 1'b1;
        end
      end
    end
  end

  // ********************************
  // Registered read port
  // ********************************
  always_comb begin
    nxt_rdata = '0;
    if (rd_i) begin
      if (aux_sel_i) begin
        nxt_rdata = aux_data_i;
      end else if (int'(rd_idx_i) < N) begin
        nxt_rdata = cnt_ff[rd_idx_i];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= nxt_rdata;
    end
  end

  property p_clear_zero;
    @(posedge mclk_i) disable iff (rst_i)
    clr_i |=> (cnt_ff[0] == '0) && (cnt_ff[N-1] == '0);
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("counter not zero after clear");

  property p_wrap_step;
    @(posedge mclk_i) disable iff (rst_i)
    (inc_i[0] && !clr_i) |=> cnt_ff[0] == W'($past(cnt_ff[0]) + 1'b1);
  endproperty
  a_wrap_step: assert property (p_wrap_step)
    else $error("counter did not step by one");
endmodule

// ==== design/port_statistics_counters.sv ====
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "port_stats_defs.svh"
module port_statistics_counters #(
  parameter int CNT_W = 32,
  parameter int SECOND_CYCLES = `SECOND_CYCLES,
  parameter logic [15:0] MAX_FRAME_RST = `MAX_FRAME_RST
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Clear-all fan in and fan out between ports
  input wire logic clear_all_i,
  output logic clear_all_o,
  // Link state
  input wire logic link_up_i,
  input wire logic [1:0] speed_i,
  input wire logic full_duplex_i,
  input wire logic stp_enable_i,
  input wire logic [2:0] stp_state_i,
  // Transmit events
  input wire logic tx_done_i,
  input wire logic tx_good_i,
  input wire port_stats_pkg::cast_type tx_cast_i,
  input wire logic tx_pause_i,
  input wire logic tx_vlan_i,
  input wire logic [4:0] tx_collisions_i,
  input wire logic [15:0] tx_len_i,
  input wire logic tx_excessive_i,
  input wire logic tx_late_col_i,
  // Receive events
  input wire logic rx_done_i,
  input wire port_stats_pkg::cast_type rx_cast_i,
  input wire logic [15:0] rx_len_i,
  input wire logic rx_crc_err_i,
  input wire logic rx_len_err_i,
  input wire logic rx_pause_i,
  input wire logic rx_ctrl_i
);
  logic [`NUM_CNT-1:0] inc;
  logic [31:0] aux_data;
  logic aux_sel;
  logic clr_port;
  logic tx_std;
  logic rx_good;
  logic rx_runt;
  logic rx_len_bad;
  logic [6:0] link_stat_ff;
  logic [2:0] nxt_state;
  logic [15:0] max_frame_ff;
  logic clear_all_ff;
  logic [31:0] sec_cnt_ff;
  logic tick_ff;
  logic [31:0] tx_acc_ff;
  logic [31:0] rx_acc_ff;
  logic [31:0] nxt_tx_acc;
  logic [31:0] nxt_rx_acc;
  logic [31:0] tx_rate_ff;
  logic [31:0] rx_rate_ff;
  logic [31:0] uptime_ff;

  function automatic logic in_range(input logic [15:0] len,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (len >= lo) && (len <= hi);
  endfunction

  // ********************************
  // Frame classification
  // ********************************
  // Pause frames are kept out of the cast counters to avoid double counts
  assign tx_std = tx_done_i && tx_good_i && !tx_pause_i;
  assign rx_runt = rx_len_i < `LEN_MIN;
  assign rx_len_bad = rx_len_err_i || (rx_len_i > max_frame_ff);
  assign rx_good = rx_done_i && !rx_crc_err_i && !rx_len_bad && !rx_runt &&
                   !rx_pause_i && !rx_ctrl_i;

  always_comb begin
    inc = '0;
    inc[`IDX_TX_FRAMES] = tx_done_i;
    inc[`IDX_RX_FRAMES] = rx_done_i;
    inc[`IDX_RX_ERRORS] = rx_done_i &&
                          (rx_crc_err_i || rx_len_bad || rx_runt);
    inc[`IDX_TX_UNI] = tx_std &&
                       (tx_cast_i == port_stats_pkg::CAST_UNI);
    inc[`IDX_TX_MULTI] = tx_std &&
                         (tx_cast_i == port_stats_pkg::CAST_MULTI);
    inc[`IDX_TX_BROAD] = tx_std &&
                         (tx_cast_i == port_stats_pkg::CAST_BROAD);
    inc[`IDX_TX_PAUSE] = tx_done_i && tx_pause_i;
    inc[`IDX_TX_TAGGED] = tx_done_i && tx_vlan_i;
    inc[`IDX_RX_UNI] = rx_good &&
                       (rx_cast_i == port_stats_pkg::CAST_UNI);
    inc[`IDX_RX_MULTI] = rx_good &&
                         (rx_cast_i == port_stats_pkg::CAST_MULTI);
    inc[`IDX_RX_BROAD] = rx_good &&
                         (rx_cast_i == port_stats_pkg::CAST_BROAD);
    inc[`IDX_RX_PAUSE] = rx_done_i && rx_pause_i && !rx_crc_err_i;
    inc[`IDX_RX_CTRL] = rx_done_i && rx_ctrl_i && !rx_pause_i;
    inc[`IDX_COL_SINGLE] = tx_done_i && tx_good_i &&
                           (tx_collisions_i == 5'h01);
    inc[`IDX_COL_MULTI] = tx_done_i && tx_good_i &&
                          (tx_collisions_i >= 5'h02);
    inc[`IDX_COL_EXCESS] = tx_excessive_i;
    inc[`IDX_COL_LATE] = tx_late_col_i;
    inc[`IDX_RX_CRC] = rx_done_i && rx_crc_err_i;
    inc[`IDX_RX_LEN] = rx_done_i && rx_len_bad;
    inc[`IDX_RX_RUNT] = rx_done_i && rx_runt;
    // Bins take good and bad frames alike
    inc[`IDX_BIN_64] = rx_done_i && (rx_len_i == `LEN_MIN);
    inc[`IDX_BIN_127] = rx_done_i &&
                        in_range(rx_len_i, `LEN_MIN + 16'h0001,
                                 `LEN_127);
    inc[`IDX_BIN_255] = rx_done_i &&
                        in_range(rx_len_i, `LEN_127 + 16'h0001,
                                 `LEN_255);
    inc[`IDX_BIN_511] = rx_done_i &&
                        in_range(rx_len_i, `LEN_255 + 16'h0001,
                                 `LEN_511);
    inc[`IDX_BIN_1023] = rx_done_i &&
                         in_range(rx_len_i, `LEN_511 + 16'h0001,
                                  `LEN_1023);
    inc[`IDX_BIN_1518] = rx_done_i &&
                         in_range(rx_len_i, `LEN_1023 + 16'h0001,
                                  `LEN_1518);
    inc[`IDX_GIANT] = rx_done_i &&
                      in_range(rx_len_i, `LEN_GIANT_MIN,
                               max_frame_ff);
  end

  // ********************************
  // Link and port state
  // ********************************
  always_comb begin
    if (stp_enable_i) begin
      nxt_state = stp_state_i;
    end else if (link_up_i) begin
      nxt_state = `STATE_FORWARDING;
    end else begin
      nxt_state = `STATE_STOP;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      link_stat_ff <= 7'h00;
    end else begin
      link_stat_ff <= {nxt_state, link_up_i, full_duplex_i, speed_i};
    end
  end

  // ********************************
  // Control register
  // ********************************
  assign clr_port = (wr_i && (addr_i == `ADDR_CTRL) &&
                     (wdata_i[`CTRL_CLR_PORT] || wdata_i[`CTRL_CLR_ALL])) ||
                    clear_all_i;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      clear_all_ff <= 1'b0;
    end else begin
      clear_all_ff <= wr_i && (addr_i == `ADDR_CTRL) &&
                      wdata_i[`CTRL_CLR_ALL];
    end
  end
  assign clear_all_o = clear_all_ff;

  // Giant ceiling differs by product, so software sets it
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      max_frame_ff <= MAX_FRAME_RST;
    end else if (wr_i && (addr_i == `ADDR_MAX_FRAME)) begin
      max_frame_ff <= wdata_i[15:0];
    end
  end

  // ********************************
  // One second tick
  // ********************************
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sec_cnt_ff <= 32'h0;
      tick_ff <= 1'b0;
    end else if (sec_cnt_ff == 32'(SECOND_CYCLES - 1)) begin
      sec_cnt_ff <= 32'h0;
      tick_ff <= 1'b1;
    end else begin
      sec_cnt_ff <= sec_cnt_ff + 32'h1;
      tick_ff <= 1'b0;
    end
  end

  // ********************************
  // Throughput
  // ********************************
  // A frame ending on the tick is counted in the closing window
  assign nxt_tx_acc = tx_acc_ff + (tx_done_i ? {16'h0, tx_len_i} : 32'h0);
  assign nxt_rx_acc = rx_acc_ff + (rx_done_i ? {16'h0, rx_len_i} : 32'h0);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_acc_ff <= 32'h0;
      rx_acc_ff <= 32'h0;
      tx_rate_ff <= 32'h0;
      rx_rate_ff <= 32'h0;
    end else if (tick_ff) begin
      tx_acc_ff <= 32'h0;
      rx_acc_ff <= 32'h0;
      tx_rate_ff <= nxt_tx_acc >> `KB_SHIFT;
      rx_rate_ff <= nxt_rx_acc >> `KB_SHIFT;
    end else begin
      tx_acc_ff <= nxt_tx_acc;
      rx_acc_ff <= nxt_rx_acc;
    end
  end

  // ********************************
  // Up time in seconds
  // ********************************
  // Resolution is one tick; hours and minutes are left to software
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      uptime_ff <= 32'h0;
    end else if (!link_up_i) begin
      uptime_ff <= 32'h0;
    end else if (tick_ff) begin
      uptime_ff <= uptime_ff + 32'h1;
    end
  end

  // ********************************
  // Register read
  // ********************************
  assign aux_sel = addr_i[7];

  always_comb begin
    unique case (addr_i)
      `ADDR_LINK: aux_data = {25'h0, link_stat_ff};
      `ADDR_TX_RATE: aux_data = tx_rate_ff;
      `ADDR_RX_RATE: aux_data = rx_rate_ff;
      `ADDR_UPTIME: aux_data = uptime_ff;
      `ADDR_MAX_FRAME: aux_data = {16'h0, max_frame_ff};
      default: aux_data = 32'h0;
    endcase
  end

  counter_bank #(
    .N(`NUM_CNT),
    .W(CNT_W),
    .AW(5)
  ) u_bank (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clr_i(clr_port),
    .inc_i(inc),
    .rd_i(rd_i),
    .rd_idx_i(addr_i[6:2]),
    .aux_sel_i(aux_sel),
    .aux_data_i(aux_data),
    .rdata_o(rdata_o)
  );

  // ********************************
  // Checks
  // ********************************
  // Looks at the stored count, not the strobe, so a lost step is caught
  property p_tx_total;
    @(posedge mclk_i) disable iff (rst_i)
    (tx_done_i && !clr_port) |=>
      u_bank.cnt_ff[`IDX_TX_FRAMES] ==
      CNT_W'($past(u_bank.cnt_ff[`IDX_TX_FRAMES]) + 1'b1);
  endproperty
  a_tx_total: assert property (p_tx_total)
    else $error("transmit total missed a frame");

  property p_rx_total;
    @(posedge mclk_i) disable iff (rst_i)
    rx_done_i |-> inc[`IDX_RX_FRAMES];
  endproperty
  a_rx_total: assert property (p_rx_total)
    else $error("receive total missed a frame");

  property p_err_runt;
    @(posedge mclk_i) disable iff (rst_i)
    (rx_done_i && rx_len_i < 16'h0040) |->
      inc[`IDX_RX_RUNT] && inc[`IDX_RX_ERRORS] && !inc[`IDX_RX_UNI];
  endproperty
  a_err_runt: assert property (p_err_runt)
    else $error("runt not counted as error");

  property p_bin_onehot;
    @(posedge mclk_i) disable iff (rst_i)
    (rx_done_i && rx_len_i >= 16'h0040 && rx_len_i <= 16'h05EE) |->
      $onehot(inc[`IDX_BIN_1518:`IDX_BIN_64]) && !inc[`IDX_GIANT];
  endproperty
  a_bin_onehot: assert property (p_bin_onehot)
    else $error("length bin not one hot");

  property p_col_excl;
    @(posedge mclk_i) disable iff (rst_i)
    !(inc[`IDX_COL_SINGLE] && inc[`IDX_COL_MULTI]);
  endproperty
  a_col_excl: assert property (p_col_excl)
    else $error("single and multiple collision together");

  property p_ctrl_no_pause;
    @(posedge mclk_i) disable iff (rst_i)
    rx_pause_i |-> !inc[`IDX_RX_CTRL];
  endproperty
  a_ctrl_no_pause: assert property (p_ctrl_no_pause)
    else $error("pause frame counted as control");

  property p_state;
    @(posedge mclk_i) disable iff (rst_i)
    (!stp_enable_i && !link_up_i) |=> link_stat_ff[6:4] == 3'h0;
  endproperty
  a_state: assert property (p_state)
    else $error("down port not shown as stopped");

  property p_uptime;
    @(posedge mclk_i) disable iff (rst_i)
    (link_up_i && tick_ff) |=> uptime_ff == $past(uptime_ff) + 32'h1;
  endproperty
  a_uptime: assert property (p_uptime)
    else $error("up time did not advance on tick");

  property p_rate;
    @(posedge mclk_i) disable iff (rst_i)
    (tick_ff && !tx_done_i) |=> tx_rate_ff == ($past(tx_acc_ff) >> 10);
  endproperty
  a_rate: assert property (p_rate)
    else $error("transmit rate not latched on tick");

  property p_clear_all_out;
    @(posedge mclk_i) disable iff (rst_i)
    (wr_i && (addr_i == `ADDR_CTRL) && wdata_i[`CTRL_CLR_ALL]) |=>
      clear_all_o;
  endproperty
  a_clear_all_out: assert property (p_clear_all_out)
    else $error("clear all pulse missing after write");

  property p_giant_cap;
    @(posedge mclk_i) disable iff (rst_i)
    (rx_done_i && (rx_len_i > max_frame_ff)) |->
      inc[`IDX_RX_LEN] && !inc[`IDX_GIANT];
  endproperty
  a_giant_cap: assert property (p_giant_cap)
    else $error("frame above ceiling counted as giant");
endmodule

// ==== design/port_stats_defs.svh ====
// Operation
// - Report speed code and full duplex
// - Forwarding or stop, else spanning state
// - Count every transmitted frame
// - Count every received frame
// - Count received frames with any error
// - Transmit and receive kilobytes per second
// - Seconds of continuous link up time
// - Count good transmit unicast, multicast, broadcast
// - Count transmitted pause frames
// - Count transmitted VLAN tagged frames
// - Count good receive unicast, multicast, broadcast
// - Count received pause frames
// - Count control frames, CRC errors included, no pause
// - Count sends after exactly one collision
// - Count sends after two or more collisions
// - Count sends abandoned on collision limit
// - Count collisions after first 512 bits
// - Count received frames failing CRC
// - Count received frames with bad length
// - Count frames under 64 octets as runts
// - Six length bins from 64 to 1518
// - Giants from 1519 to maximum frame size
// - Clear this port or all ports
`ifndef PORT_STATS_DEFS_SVH
`define PORT_STATS_DEFS_SVH

// ********************************
// Counter indices
// ********************************
`define NUM_CNT 27
`define IDX_TX_FRAMES 5'h00
`define IDX_RX_FRAMES 5'h01
`define IDX_RX_ERRORS 5'h02
`define IDX_TX_UNI 5'h03
`define IDX_TX_MULTI 5'h04
`define IDX_TX_BROAD 5'h05
`define IDX_TX_PAUSE 5'h06
`define IDX_TX_TAGGED 5'h07
`define IDX_RX_UNI 5'h08
`define IDX_RX_MULTI 5'h09
`define IDX_RX_BROAD 5'h0A
`define IDX_RX_PAUSE 5'h0B
`define IDX_RX_CTRL 5'h0C
`define IDX_COL_SINGLE 5'h0D
`define IDX_COL_MULTI 5'h0E
`define IDX_COL_EXCESS 5'h0F
`define IDX_COL_LATE 5'h10
`define IDX_RX_CRC 5'h11
`define IDX_RX_LEN 5'h12
`define IDX_RX_RUNT 5'h13
`define IDX_BIN_64 5'h14
`define IDX_BIN_127 5'h15
`define IDX_BIN_255 5'h16
`define IDX_BIN_511 5'h17
`define IDX_BIN_1023 5'h18
`define IDX_BIN_1518 5'h19
`define IDX_GIANT 5'h1A

// ********************************
// Register byte addresses
// ********************************
`define ADDR_LINK 8'h80
`define ADDR_TX_RATE 8'h84
`define ADDR_RX_RATE 8'h88
`define ADDR_UPTIME 8'h8C
`define ADDR_CTRL 8'h90
`define ADDR_MAX_FRAME 8'h94

// ********************************
// Fields and values
// ********************************
`define CTRL_CLR_PORT 0
`define CTRL_CLR_ALL 1
`define SPEED_100M 2'h0
`define SPEED_1000M 2'h1
`define SPEED_10G 2'h2
`define STATE_STOP 3'h0
`define STATE_FORWARDING 3'h4
`define LEN_MIN 16'h0040
`define LEN_127 16'h007F
`define LEN_255 16'h00FF
`define LEN_511 16'h01FF
`define LEN_1023 16'h03FF
`define LEN_1518 16'h05EE
`define LEN_GIANT_MIN 16'h05EF
`define MAX_FRAME_RST 16'h2400
`define KB_SHIFT 10

// ********************************
// Timing
// ********************************
`define SECOND_NS 1000000000
`define CLK_PERIOD_NS 40
`define SECOND_CYCLES (`SECOND_NS / `CLK_PERIOD_NS)

`endif

// ==== design/port_stats_pkg.sv ====
package port_stats_pkg;
  typedef enum logic [1:0] {
    CAST_UNI,
    CAST_MULTI,
    CAST_BROAD
  } cast_type;
endpackage

// ==== sim/mac_model.sv ====
`timescale 1ns/10ps
module mac_model (
  input wire logic mclk_i,
  output logic tx_done_o,
  output logic [2:0] tx_flags_o,
  output port_stats_pkg::cast_type tx_cast_o,
  output logic [4:0] tx_col_o,
  output logic [15:0] tx_len_o,
  output logic tx_exc_o,
  output logic tx_late_o,
  output logic rx_done_o,
  output port_stats_pkg::cast_type rx_cast_o,
  output logic [15:0] rx_len_o,
  output logic [3:0] rx_flags_o
);
  initial begin
    tx_done_o = 1'b0;
    tx_flags_o = 3'h0;
    tx_cast_o = port_stats_pkg::CAST_UNI;
    tx_col_o = 5'h00;
    tx_len_o = 16'h0000;
    tx_exc_o = 1'b0;
    tx_late_o = 1'b0;
    rx_done_o = 1'b0;
    rx_cast_o = port_stats_pkg::CAST_UNI;
    rx_len_o = 16'h0000;
    rx_flags_o = 4'h0;
  end

  // Flags: good, pause, vlan. Qualifiers are scrambled after the pulse
  // so a design that samples them late sees garbage.
  task send_tx(input logic [15:0] len, input port_stats_pkg::cast_type c,
               input logic [2:0] f, input logic [4:0] col);
    @(posedge mclk_i);
    tx_done_o <= 1'b1;
    tx_len_o <= len;
    tx_cast_o <= c;
    tx_flags_o <= f;
    tx_col_o <= col;
    @(posedge mclk_i);
    tx_done_o <= 1'b0;
    tx_len_o <= ~len;
    tx_cast_o <= port_stats_pkg::cast_type'(~c);
    tx_flags_o <= ~f;
    tx_col_o <= ~col;
  endtask

  // Flags: crc error, length error, pause, control
  task send_rx(input logic [15:0] len, input port_stats_pkg::cast_type c,
               input logic [3:0] f);
    @(posedge mclk_i);
    rx_done_o <= 1'b1;
    rx_len_o <= len;
    rx_cast_o <= c;
    rx_flags_o <= f;
    @(posedge mclk_i);
    rx_done_o <= 1'b0;
    rx_len_o <= ~len;
    rx_cast_o <= port_stats_pkg::cast_type'(~c);
    rx_flags_o <= ~f;
  endtask

  task pulse(input logic late);
    @(posedge mclk_i);
    tx_late_o <= late;
    tx_exc_o <= ~late;
    @(posedge mclk_i);
    tx_late_o <= 1'b0;
    tx_exc_o <= 1'b0;
  endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/10ps
`include "port_stats_defs.svh"
module testbench;
  // Short second keeps the rate and uptime checks within a few hundred cycles
  localparam int SEC = 100;
  localparam int LENS [6] = '{100, 200, 300, 600, 1200, 1600};
  localparam port_stats_pkg::cast_type UNI = port_stats_pkg::CAST_UNI;
  localparam port_stats_pkg::cast_type MUL = port_stats_pkg::CAST_MULTI;
  localparam port_stats_pkg::cast_type BRD = port_stats_pkg::CAST_BROAD;
  logic mclk_i, rst_i, wr_i, rd_i, clear_all_i, clear_all_o;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic link_up_i, full_duplex_i, stp_enable_i;
  logic [1:0] speed_i;
  logic [2:0] stp_state_i, tx_f;
  logic tx_done, tx_exc, tx_late, rx_done;
  port_stats_pkg::cast_type tx_cast, rx_cast;
  logic [4:0] tx_col;
  logic [15:0] tx_len, rx_len;
  logic [3:0] rx_f;
  logic [31:0] exp_cnt [27];
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;

  port_statistics_counters #(.SECOND_CYCLES(SEC)) i_port_statistics_counters (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .clear_all_i(clear_all_i), .clear_all_o(clear_all_o),
    .link_up_i(link_up_i), .speed_i(speed_i),
    .full_duplex_i(full_duplex_i), .stp_enable_i(stp_enable_i),
    .stp_state_i(stp_state_i), .tx_done_i(tx_done), .tx_good_i(tx_f[2]),
    .tx_cast_i(tx_cast), .tx_pause_i(tx_f[1]), .tx_vlan_i(tx_f[0]),
    .tx_collisions_i(tx_col), .tx_len_i(tx_len), .tx_excessive_i(tx_exc),
    .tx_late_col_i(tx_late), .rx_done_i(rx_done), .rx_cast_i(rx_cast),
    .rx_len_i(rx_len), .rx_crc_err_i(rx_f[3]), .rx_len_err_i(rx_f[2]),
    .rx_pause_i(rx_f[1]), .rx_ctrl_i(rx_f[0]));

  mac_model i_mac_model (
    .mclk_i(mclk_i), .tx_done_o(tx_done), .tx_flags_o(tx_f),
    .tx_cast_o(tx_cast), .tx_col_o(tx_col), .tx_len_o(tx_len),
    .tx_exc_o(tx_exc), .tx_late_o(tx_late), .rx_done_o(rx_done),
    .rx_cast_o(rx_cast), .rx_len_o(rx_len), .rx_flags_o(rx_f));

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  task complete_run;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Ceiling sits well above the several hundred cycles the tests need
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    wdata_i <= ~d;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task chk_all;
    logic [31:0] v;
    for (int k = 0; k < `NUM_CNT; k++) begin
      rd(8'(4 * k), v);
      check(v, exp_cnt[k]);
    end
  endtask

  task zero_exp;
    for (int k = 0; k < `NUM_CNT; k++) begin
      exp_cnt[k] = 32'h0;
    end
  endtask

  // Negative index means no further counter moves
  task bump(input int a, input int b, input int c, input int d);
    exp_cnt[a]++;
    if (b >= 0) exp_cnt[b]++;
    if (c >= 0) exp_cnt[c]++;
    if (d >= 0) exp_cnt[d]++;
  endtask

  task lk(input logic up, input logic en, input logic [2:0] st,
          input logic [1:0] sp, input logic [2:0] want);
    logic [31:0] v;
    @(posedge mclk_i);
    link_up_i <= up;
    stp_enable_i <= en;
    stp_state_i <= st;
    speed_i <= sp;
    full_duplex_i <= sp[0];
    repeat (3) @(posedge mclk_i);
    rd(`ADDR_LINK, v);
    check(v, {25'h0, want, up, sp[0], sp});
  endtask

  initial begin
    logic [31:0] v;
    int ones;
    int c;
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    clear_all_i = 1'b0;
    link_up_i = 1'b1;
    speed_i = 2'h1;
    full_duplex_i = 1'b1;
    stp_enable_i = 1'b0;
    stp_state_i = 3'h0;
    zero_exp;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    // Rates: 2048 tx and 3072 rx bytes, all inside the first second
    i_mac_model.send_tx(16'h0400, UNI, 3'h4, 5'h00);
    i_mac_model.send_tx(16'h0400, UNI, 3'h4, 5'h00);
    i_mac_model.send_rx(16'h0C00, UNI, 4'h0);
    bump(0, 3, -1, -1);
    bump(0, 3, -1, -1);
    bump(1, 8, 26, -1);
    repeat (140) @(posedge mclk_i);
    rd(`ADDR_TX_RATE, v);
    check(v, 32'h2);
    rd(`ADDR_RX_RATE, v);
    check(v, 32'h3);
    rd(`ADDR_UPTIME, v);
    check(v, 32'h1);
    rd(`ADDR_MAX_FRAME, v);
    check(v, 32'h0000_2400);
    rd(8'h70, v);
    check(v, 32'h0);
    wr(8'h00, 32'h0000_0055);
    wr(8'h70, 32'h0000_00AA);
    chk_all;
    $display("test rates done");
    fork
      wr(`ADDR_CTRL, 32'h2);
      begin
        ones = 0;
        repeat (4) begin
          @(posedge mclk_i);
          #1 ones += int'(clear_all_o);
        end
      end
    join
    check(32'(ones), 32'h1);
    zero_exp;
    chk_all;
    $display("test clear all done");
    i_mac_model.send_rx(16'h0040, UNI, 4'h0);
    bump(1, 8, 20, -1);
    for (int i = 0; i < 6; i++) begin
      c = (i < 2) ? i + 1 : 0;
      i_mac_model.send_rx(16'(LENS[i]), port_stats_pkg::cast_type'(c), 4'h0);
      bump(1, 8 + c, 21 + i, -1);
    end
    i_mac_model.send_rx(16'h0046, UNI, 4'h8);
    bump(1, 2, 17, 21);
    i_mac_model.send_rx(16'h0028, UNI, 4'h0);
    bump(1, 2, 19, -1);
    i_mac_model.send_rx(16'h003F, UNI, 4'h8);
    bump(1, 2, 17, 19);
    i_mac_model.send_rx(16'h0050, BRD, 4'h4);
    bump(1, 2, 18, 21);
    i_mac_model.send_rx(16'h0040, MUL, 4'h2);
    bump(1, 11, 20, -1);
    i_mac_model.send_rx(16'h0040, UNI, 4'h9);
    bump(1, 12, 17, 20);
    bump(2, -1, -1, -1);
    i_mac_model.send_rx(16'h0040, MUL, 4'h3);
    bump(1, 11, 20, -1);
    wr(`ADDR_MAX_FRAME, 32'h0000_0100);
    rd(`ADDR_MAX_FRAME, v);
    check(v, 32'h0000_0100);
    i_mac_model.send_rx(16'h012C, UNI, 4'h0);
    bump(1, 2, 18, 23);
    i_mac_model.send_rx(16'h00F0, UNI, 4'h0);
    bump(1, 8, 22, -1);
    wr(`ADDR_MAX_FRAME, 32'h0000_2400);
    chk_all;
    $display("test receive done");
    i_mac_model.send_tx(16'h0040, UNI, 3'h4, 5'h00);
    bump(0, 3, -1, -1);
    i_mac_model.send_tx(16'h0040, MUL, 3'h4, 5'h01);
    bump(0, 4, 13, -1);
    i_mac_model.send_tx(16'h0040, BRD, 3'h4, 5'h03);
    bump(0, 5, 14, -1);
    i_mac_model.send_tx(16'h0040, UNI, 3'h4, 5'h02);
    bump(0, 3, 14, -1);
    i_mac_model.send_tx(16'h0040, UNI, 3'h6, 5'h00);
    bump(0, 6, -1, -1);
    i_mac_model.send_tx(16'h0040, MUL, 3'h5, 5'h00);
    bump(0, 4, 7, -1);
    i_mac_model.send_tx(16'h0040, UNI, 3'h0, 5'h01);
    bump(0, -1, -1, -1);
    i_mac_model.pulse(1'b0);
    exp_cnt[15]++;
    i_mac_model.pulse(1'b1);
    i_mac_model.pulse(1'b1);
    exp_cnt[16] += 32'h2;
    chk_all;
    $display("test transmit done");
    wr(`ADDR_CTRL, 32'h1);
    zero_exp;
    chk_all;
    i_mac_model.send_tx(16'h0040, UNI, 3'h4, 5'h00);
    // Frame lands in the clear cycle, so it must be lost
    fork
      i_mac_model.send_rx(16'h0040, UNI, 4'h0);
      begin
        @(posedge mclk_i);
        clear_all_i <= 1'b1;
        @(posedge mclk_i);
        clear_all_i <= 1'b0;
      end
    join
    chk_all;
    $display("test port clear done");
    lk(1'b1, 1'b0, 3'h5, `SPEED_100M, `STATE_FORWARDING);
    lk(1'b1, 1'b0, 3'h5, `SPEED_1000M, `STATE_FORWARDING);
    lk(1'b1, 1'b0, 3'h1, `SPEED_10G, `STATE_FORWARDING);
    lk(1'b0, 1'b0, 3'h6, `SPEED_10G, `STATE_STOP);
    lk(1'b1, 1'b1, 3'h2, `SPEED_1000M, 3'h2);
    lk(1'b0, 1'b1, 3'h3, `SPEED_100M, 3'h3);
    rd(`ADDR_UPTIME, v);
    check(v, 32'h0);
    $display("test link done");
    complete_run;
  end
endmodule
